// ### design/dbg_top.v
// dead-band generator top with classic wishbone register slave
//
// Notes on behaviour
// RQ1: outputs are derived from the two action-qualifier inputs a and b.
// RQ2: source select picks a or b for rising and falling delay paths.
// RQ3: apply select chooses none, falling, rising or both delays.
// RQ4: with both delays applied, polarity bits invert rising and falling delayed paths independently.
// RQ5: apply bits zero pass inputs straight through, polarity ignored.
// RQ6: both applied, polarity 10 complementary high, 00 plain high.
// RQ7: both applied, polarity 01 complementary low, 11 both inverted.
// RQ8: apply 01: a passes, b is the falling-delayed path (input a for source select 0 or 1).
// RQ9: apply 10: a is the rising-delayed path (input a for source select 0 or 2), b passes.
// RQ10: polarity in bits 3:2, apply in bits 1:0, all combinations.
// RQ11: rising and falling delays have separate independent registers.
// RQ12: ten-bit counts delay an edge by that many ticks.
// RQ13: no shadow copies; writes act at once.
// RQ14: with both delays applied, bit 2 inverts rising path to a, bit 3 falling path to b.
// RQ15: zero count means no delay; each delay hits one edge kind.
// RQ16: state moves on tick enable; all registers reset to zero.
`include "dbg_defs.vh"

module dbg_top
(
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] adr_i,
    input wire [31:0] dat_i,
    output wire [31:0] dat_o,
    input wire [3:0] sel_i,
    input wire we_i,
    input wire cyc_i,
    input wire stb_i,
    output wire ack_o,
    input wire time_base_tick_i,
    input wire pwm_a_i,
    input wire pwm_b_i,
    output wire pwm_output_a_o,
    output wire pwm_output_b_o
);

reg [`DBG_CTL_W-1:0] ctl_q;
reg [`DBG_CNT_W-1:0] red_cnt_q;
reg [`DBG_CNT_W-1:0] fed_cnt_q;
reg ack_q;
reg [31:0] rdat_q;
reg out_a_q;
reg out_b_q;
wire req;
wire wr;
wire [`DBG_IDX_W-1:0] idx;
wire [1:0] src_sel;
wire [1:0] path_src;
wire [1:0] path_dly;
wire [1:0] path_busy;
wire [`DBG_CNT_W-1:0] path_cnt [0:1];
wire mux_a;
wire mux_b;
reg ack_d;
reg [`DBG_CTL_W-1:0] ctl_d;
reg [`DBG_CNT_W-1:0] red_cnt_d;
reg [`DBG_CNT_W-1:0] fed_cnt_d;
reg [31:0] rdat_d;
reg out_a_d;
reg out_b_d;
wire req_take;
wire hit_ctl;
wire hit_red;
wire hit_fed;
wire hit_stat;
wire wr_ctl;
wire wr_red;
wire wr_fed;
wire [`DBG_REG_W-1:0] ctl_wdat;
wire [`DBG_REG_W-1:0] red_wdat;
wire [`DBG_REG_W-1:0] fed_wdat;
wire [5:0] stat_word;

// ********************************
// merge byte lanes into a 16-bit register
// ********************************
function [`DBG_REG_W-1:0] lane_merge;
    input [`DBG_REG_W-1:0] old;
    input [31:0] wdat;
    input [3:0] sel;
    begin
        lane_merge = old;
        if (sel[0])
            lane_merge[7:0] = wdat[7:0];
        if (sel[1])
            lane_merge[15:8] = wdat[15:8];
    end
endfunction

// ********************************
// source of a delay path
// ********************************
function path_source;
    input [1:0] sel;
    input fall;
    input a;
    input b;
    begin
        case (sel)
            `DBG_SRC_A_BOTH:
                path_source = a;
            `DBG_SRC_B_RISE:
                path_source = fall ? a : b;
            `DBG_SRC_B_FALL:
                path_source = fall ? b : a;
            `DBG_SRC_B_BOTH:
                path_source = b;
            default:
                path_source = a;
        endcase
    end
endfunction

// ********************************
// register index match
// ********************************
function reg_hit;
    input [`DBG_IDX_W-1:0] cur;
    input [`DBG_IDX_W-1:0] target;
    begin
        reg_hit = (cur == target);
    end
endfunction

// ********************************
// bus decode
// ********************************
assign req = cyc_i & stb_i;
assign wr = req & we_i & ack_q;
assign idx = adr_i[`DBG_IDX_W+1:2];
assign ack_o = ack_q;
assign dat_o = rdat_q;
assign req_take = req & ~ack_q;
assign hit_ctl = reg_hit(idx, `DBG_IDX_CTL);
assign hit_red = reg_hit(idx, `DBG_IDX_RED);
assign hit_fed = reg_hit(idx, `DBG_IDX_FED);
assign hit_stat = reg_hit(idx, `DBG_IDX_STAT);

always @*
begin
    ack_d = req_take;
end

always @(posedge clk_i)
begin
    if (rst_i)
        ack_q <= 1'b0;
    else
        ack_q <= ack_d;
end

// ********************************
// register writes
// ********************************
assign ctl_wdat = lane_merge({{10{1'b0}}, ctl_q}, dat_i, sel_i);
assign red_wdat = lane_merge({{6{1'b0}}, red_cnt_q}, dat_i, sel_i);
assign fed_wdat = lane_merge({{6{1'b0}}, fed_cnt_q}, dat_i, sel_i);
assign wr_ctl = wr & hit_ctl;
assign wr_red = wr & hit_red;
assign wr_fed = wr & hit_fed;

// ********************************
// next register values
// ********************************
always @*
begin
    ctl_d = ctl_q;
    red_cnt_d = red_cnt_q;
    fed_cnt_d = fed_cnt_q;
    // RQ13: direct unshadowed write
    // RQ10: control field layout
    if (wr_ctl)
        ctl_d = ctl_wdat[`DBG_CTL_W-1:0];
    // RQ11: separate delay registers
    if (wr_red)
        red_cnt_d = red_wdat[`DBG_CNT_W-1:0];
    // RQ12: ten-bit count field
    if (wr_fed)
        fed_cnt_d = fed_wdat[`DBG_CNT_W-1:0];
end

always @(posedge clk_i)
begin
    // RQ16: zero at reset
    if (rst_i)
    begin
        ctl_q <= `DBG_CTL_RST;
        red_cnt_q <= `DBG_CNT_RST;
        fed_cnt_q <= `DBG_CNT_RST;
    end
    else
    begin
        ctl_q <= ctl_d;
        red_cnt_q <= red_cnt_d;
        fed_cnt_q <= fed_cnt_d;
    end
end

// ********************************
// status word
// ********************************
assign stat_word = {out_b_q, out_a_q, path_busy, path_dly};

// ********************************
// read data
// ********************************
always @*
begin
    rdat_d = rdat_q;
    if (req_take)
    begin
        if (hit_ctl)
            rdat_d = {{26{1'b0}}, ctl_q};
        else if (hit_red)
            rdat_d = {{22{1'b0}}, red_cnt_q};
        else if (hit_fed)
            rdat_d = {{22{1'b0}}, fed_cnt_q};
        else if (hit_stat)
            rdat_d = {{26{1'b0}}, stat_word};
        else
            rdat_d = 32'h00000000;
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
        rdat_q <= 32'h00000000;
    else
        rdat_q <= rdat_d;
end

// ********************************
// delay paths: 0 rising, 1 falling
// ********************************
assign src_sel = ctl_q[`DBG_CTL_SRC_HI:`DBG_CTL_SRC_LO];
// RQ1: sources from inputs a, b
// RQ2: per-path source select
assign path_src[0] = path_source(src_sel, 1'b0, pwm_a_i, pwm_b_i);
assign path_src[1] = path_source(src_sel, 1'b1, pwm_a_i, pwm_b_i);
assign path_cnt[0] = red_cnt_q;
assign path_cnt[1] = fed_cnt_q;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_path
        // RQ15: one edge kind each
        dbg_edge_delay #(
            .DLY_LVL(g == 0 ? 1'b1 : 1'b0)
        ) u_dly (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(time_base_tick_i),
            .src_i(path_src[g]),
            .count_i(path_cnt[g]),
            .dly_o(path_dly[g]),
            .busy_o(path_busy[g])
        );
    end
endgenerate

// ********************************
// output selection and registers
// ********************************
dbg_out_sel u_sel (
    .ctl_i(ctl_q),
    .in_a_i(pwm_a_i),
    .in_b_i(pwm_b_i),
    .red_i(path_dly[0]),
    .fed_i(path_dly[1]),
    .out_a_o(mux_a),
    .out_b_o(mux_b)
);

always @*
begin
    out_a_d = mux_a;
    out_b_d = mux_b;
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        out_a_q <= 1'b0;
        out_b_q <= 1'b0;
    end
    else
    begin
        out_a_q <= out_a_d;
        out_b_q <= out_b_d;
    end
end

assign pwm_output_a_o = out_a_q;
assign pwm_output_b_o = out_b_q;

endmodule // dbg_top

// ### include/dbg_defs.vh
// constants for the dead-band generator
`ifndef DBG_DEFS_VH
`define DBG_DEFS_VH

// ********************************
// register indices (byte addr = 4 * index)
// ********************************
`define DBG_IDX_W 5
`define DBG_IDX_CTL 5'h0F
`define DBG_IDX_RED 5'h10
`define DBG_IDX_FED 5'h11
`define DBG_IDX_STAT 5'h1F

// ********************************
// control register fields
// ********************************
`define DBG_CTL_W 6
`define DBG_CTL_APPLY_FED 0
`define DBG_CTL_APPLY_RED 1
`define DBG_CTL_POL_RED 2
`define DBG_CTL_POL_FED 3
`define DBG_CTL_SRC_LO 4
`define DBG_CTL_SRC_HI 5

// ********************************
// source select encodings
// ********************************
`define DBG_SRC_A_BOTH 2'h0
`define DBG_SRC_B_RISE 2'h1
`define DBG_SRC_B_FALL 2'h2
`define DBG_SRC_B_BOTH 2'h3

// ********************************
// widths and reset values
// ********************************
`define DBG_CNT_W 10
`define DBG_REG_W 16
`define DBG_CTL_RST 6'h00
`define DBG_CNT_RST 10'h000

`endif

// ### design/dbg_edge_delay.v
// one edge-delay path: delays one kind of transition by a tick count
`include "dbg_defs.vh"

module dbg_edge_delay
#(
    parameter DLY_LVL = 1'b1
)
(
    input wire clk_i,
    input wire rst_i,
    input wire tick_i,
    input wire src_i,
    input wire [`DBG_CNT_W-1:0] count_i,
    output wire dly_o,
    output wire busy_o
);

reg out_q;
reg [`DBG_CNT_W-1:0] cnt_q;

// ********************************
// delay counter
// ********************************
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        out_q <= 1'b0;
        cnt_q <= `DBG_CNT_RST;
    end
    // RQ16: tick-paced update
    else if (tick_i)
    begin
        // RQ15: other edge undelayed
        if (src_i != DLY_LVL)
        begin
            out_q <= src_i;
            cnt_q <= `DBG_CNT_RST;
        end
        else if (out_q != src_i)
        begin
            // RQ12: exact count periods
            if (cnt_q >= count_i)
            begin
                out_q <= src_i;
                cnt_q <= `DBG_CNT_RST;
            end
            else
            begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
end

assign dly_o = out_q;
assign busy_o = (out_q != src_i);

endmodule // dbg_edge_delay

// ### design/dbg_out_sel.v
// output routing and polarity for the dead-band generator
`include "dbg_defs.vh"

module dbg_out_sel
(
    input wire [`DBG_CTL_W-1:0] ctl_i,
    input wire in_a_i,
    input wire in_b_i,
    input wire red_i,
    input wire fed_i,
    output reg out_a_o,
    output reg out_b_o
);

wire both;
wire red_pol;
wire fed_pol;

assign both = ctl_i[`DBG_CTL_APPLY_RED] & ctl_i[`DBG_CTL_APPLY_FED];
// RQ4: independent inversion
// RQ14: s2 rising, s3 falling
assign red_pol = red_i ^ ctl_i[`DBG_CTL_POL_RED];
assign fed_pol = fed_i ^ ctl_i[`DBG_CTL_POL_FED];

// ********************************
// output mux
// ********************************
always @*
begin
    out_a_o = in_a_i;
    out_b_o = in_b_i;
    // RQ3: apply select
    case ({ctl_i[`DBG_CTL_APPLY_RED], ctl_i[`DBG_CTL_APPLY_FED]})
        // RQ5: full bypass
        2'b00:
        begin
            out_a_o = in_a_i;
            out_b_o = in_b_i;
        end
        // RQ8: falling only on b
        2'b01:
        begin
            out_a_o = in_a_i;
            out_b_o = fed_i;
        end
        // RQ9: rising only on a
        2'b10:
        begin
            out_a_o = red_i;
            out_b_o = in_b_i;
        end
        // RQ6: both applied modes
        // RQ7: inverted pair modes
        2'b11:
        begin
            out_a_o = both ? red_pol : red_i;
            out_b_o = both ? fed_pol : fed_i;
        end
        default:
        begin
            out_a_o = in_a_i;
            out_b_o = in_b_i;
        end
    endcase
end

endmodule // dbg_out_sel

// ### sim/dbg_aq_model.sv
// stand-in for the action qualifier driving both pwm inputs
module dbg_aq_model (
    input wire clk_i,
    input wire [1:0] lvl_i,
    output logic pwm_a_o,
    output logic pwm_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {pwm_a_o, pwm_b_o} = 2'h0;
    always @(posedge clk_i)
    begin
        pwm_a_o <= lvl_i[0];
        pwm_b_o <= lvl_i[1];
    end
endmodule // dbg_aq_model

// ### sim/dbg_top_assertions.sv
// checker for the dead-band top
module dbg_chk (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] adr_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire [3:0] sel_i,
    input wire we_i,
    input wire cyc_i,
    input wire stb_i,
    input wire ack_o,
    input wire pwm_a_i,
    input wire pwm_b_i,
    input wire pwm_output_a_o,
    input wire pwm_output_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // **********
    // control copy
    // **********
    logic [5:0] ctl_q;
    wire rq = cyc_i && stb_i;
    wire ctl = adr_i[6:2] == 5'h0F;
    always @(posedge clk_i)
    begin
        if (rst_i)
            ctl_q <= 6'h00;
        else if (ack_o && we_i && ctl && sel_i[0])
            ctl_q <= dat_i[5:0];
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack held");
    AST_ACK_REQ: assert property (rq && !ack_o |=> ack_o)
        else $error("no ack");
    AST_ACK_IDLE: assert property (!rq |=> !ack_o)
        else $error("stray ack");
    AST_CTL_READ: assert property (ack_o && !we_i && ctl |->
        dat_o == {26'h0, ctl_q}) else $error("ctl read");
    AST_BYP_A: assert property ($past(ctl_q[1:0]) == 2'h0 |->
        pwm_output_a_o == $past(pwm_a_i)) else $error("bypass a");
    AST_BYP_B: assert property ($past(ctl_q[1:0]) == 2'h0 |->
        pwm_output_b_o == $past(pwm_b_i)) else $error("bypass b");
    AST_FED_ONLY: assert property ($past(ctl_q[1:0]) == 2'h1 |->
        pwm_output_a_o == $past(pwm_a_i)) else $error("mode 1 a");
    AST_RED_ONLY: assert property ($past(ctl_q[1:0]) == 2'h2 |->
        pwm_output_b_o == $past(pwm_b_i)) else $error("mode 2 b");
    AST_AH_RISE: assert property (ctl_q == 6'h03 &&
        $past(ctl_q, 3) == 6'h03 && $rose(pwm_output_a_o) |->
        $past(pwm_a_i, 2) || $past(pwm_a_i, 3)) else $error("rise a");
    AST_AH_FALL: assert property (ctl_q == 6'h03 &&
        $past(ctl_q, 3) == 6'h03 && $fell(pwm_output_b_o) |->
        !$past(pwm_a_i, 2) || !$past(pwm_a_i, 3)) else $error("fall b");
    cover property (ack_o && we_i);
    cover property (ctl_q == 6'h0B && $rose(pwm_output_a_o));
    cover property (ctl_q == 6'h03 && $fell(pwm_output_b_o));
endmodule // dbg_chk

bind dbg_top dbg_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pwm_a_i(pwm_a_i),
    .pwm_b_i(pwm_b_i), .pwm_output_a_o(pwm_output_a_o),
    .pwm_output_b_o(pwm_output_b_o));

// ### sim/dbg_top_tb.sv
// bench for the dead-band top
module dbg_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, cyc_i = 1'h0;
    logic stb_i = 1'h0, tick = 1'h1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, rdat;
    logic [3:0] sel_i = 4'h0;
    logic [1:0] lvl = 2'h0;
    wire [31:0] dat_o;
    wire ack_o, pa, pb, oa, ob;
    int bad_count = 0, compares = 0, cnt = 0, r, f, r0, f0;
    logic [7:0] tbl [10] = '{8'h31, 8'h0F, 8'h2D, 8'h1E, 8'h3C,
        8'h37, 8'h39, 8'h4E, 8'h8D, 8'hCC};
    dbg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .time_base_tick_i(tick), .pwm_a_i(pa), .pwm_b_i(pb),
        .pwm_output_a_o(oa), .pwm_output_b_o(ob));
    dbg_aq_model u_aq (.clk_i(clk_i), .lvl_i(lvl), .pwm_a_o(pa),
        .pwm_b_o(pb));
    always #5 clk_i = ~clk_i;
    // **********
    // tasks
    // **********
    task finish_test;
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %0t: %h vs %h", $time, s, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        @(posedge clk_i);
        while (ack_o !== 1'h1)
            @(posedge clk_i);
        rdat = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(rdat, e);
    endtask
    task settle(input logic [1:0] l, input logic [1:0] e);
        lvl <= l;
        repeat (40) @(posedge clk_i);
        #1;
        chk({30'h0, ob, oa}, {30'h0, e});
    endtask
    task lat(input logic l, output int n);
        @(posedge clk_i);
        lvl <= {1'h0, l};
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        while ((l ? oa : ob) !== l && n < 999);
    endtask
    always @(posedge clk_i)
    begin
        cnt++;
        if (cnt == 20000)
        begin
            bad_count++;
            finish_test;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(8'h3C, 0);
        rd(8'h40, 0);
        rd(8'h44, 0);
        rd(8'h00, 0);
        bus(1'h1, 8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h3FF);
        rd(8'h44, 0);
        bus(1'h1, 8'h3C, 32'h3);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'h1, 8'h40, 3 * i);
            bus(1'h1, 8'h44, 5 * i);
            settle(2'h0, 2'h0);
            lat(1'h1, r);
            settle(2'h1, 2'h3);
            lat(1'h0, f);
            if (i == 0)
            begin
                r0 = r;
                f0 = f;
            end
            chk(r - r0, 3 * i);
            chk(f - f0, 5 * i);
        end
        @(posedge clk_i);
        tick <= 1'h0;
        settle(2'h1, 2'h0);
        @(posedge clk_i);
        tick <= 1'h1;
        settle(2'h1, 2'h3);
        rd(8'h7C, 32'h33);
        foreach (tbl[i])
        begin
            bus(1'h1, 8'h3C, 32'(tbl[i][7:2]));
            rd(8'h3C, 32'(tbl[i][7:2]));
            settle(2'h1, tbl[i][1:0]);
            settle(2'h2, ~tbl[i][1:0]);
        end
        finish_test;
    end
endmodule // dbg_top_tb
